// file: logic/twsd_pkg.sv
package twsd_pkg;
  // ----------------------------------------------------------------
  // Addressing and command codes
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_FIXED_ONE_PIN = 6'h3b;  // 111011x
  localparam logic [4:0] ADDR_FIXED_TWO_PIN = 5'h1d;  // 11101yx
  localparam logic [7:0] GCALL_ADDR_BYTE    = 8'h00;
  localparam logic [7:0] GCALL_RESET_BYTE   = 8'h06;
  localparam logic [4:0] HS_CODE_TOP        = 5'h01;  // 00001xxx
  localparam logic [2:0] CMD_OTP_WRITE      = 3'h2;   // 010
  localparam logic [2:0] CMD_ACQUIRE        = 3'h1;   // 001
  // ----------------------------------------------------------------
  // Converter and store
  // ----------------------------------------------------------------
  localparam int         DAC_W        = 10;
  localparam logic [9:0] DAC_MID      = 10'h200;
  localparam logic [9:0] DAC_ZERO     = 10'h000;
  localparam logic [3:0] OTP_NONE     = 4'h0;
  localparam logic [3:0] OTP_FULL     = 4'hf;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam int         SYNC_STAGES  = 2;

  // Line samples travelling together
  typedef struct packed {
    logic scl;
    logic sda;
  } twsd_lines_t;

  // Bus events in one cycle
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } twsd_events_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_ACK   = 7'b0000100,
    ST_WRX   = 7'b0001000,
    ST_RDTX  = 7'b0010000,
    ST_RDACK = 7'b0100000,
    ST_GCALL = 7'b1000000
  } twsd_state_t;
endpackage : twsd_pkg

// file: logic/twsd_sync.sv
`timescale 1ns/100ps
`default_nettype none
module twsd_sync (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire twsd_pkg::twsd_lines_t lines_in,
  output var  twsd_pkg::twsd_lines_t lines_out
);
  // Stage one only feeds stage two to keep metastability contained
  twsd_pkg::twsd_lines_t meta_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q    <= '1;
      lines_out <= '1;
    end else begin
      meta_q    <= lines_in;
      lines_out <= meta_q;
    end
  end
endmodule : twsd_sync
`default_nettype wire

// file: logic/twsd_events.sv
`timescale 1ns/100ps
`default_nettype none
module twsd_events (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire twsd_pkg::twsd_lines_t lines,
  output var  twsd_pkg::twsd_events_t ev
);
  // Previous synchronised sample, the only history edges need
  twsd_pkg::twsd_lines_t prev_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= '1;
    end else begin
      prev_q <= lines;
    end
  end
  // Data moving while clock stays high is a condition, not data
  always_comb begin
    ev.start = prev_q.scl & lines.scl & prev_q.sda & ~lines.sda;
    ev.stop  = prev_q.scl & lines.scl & ~prev_q.sda & lines.sda;
    ev.rise  = ~prev_q.scl & lines.scl;
    ev.fall  = prev_q.scl & ~lines.scl;
  end
endmodule : twsd_events
`default_nettype wire

// file: logic/twsd_front_end.sv
// Overview of operation
// - One-pin variant matches 111011 plus low select pin level.
// - Two-pin variant matches 11101, high select, low select.
// - Slave only; clock line is purely an input, never driven.
// - START is data falling while clock high; detected here.
// - STOP is data rising while clock high; ends any transfer.
// - Matching address byte is acknowledged on the ninth clock.
// - Every transfer is eight bits then one acknowledge bit.
// - Address direction bit: high reads, low writes.
// - Standard and fast rates need no activation.
// - High-speed master code recognised for any low bits, not acked.
// - After master code, high-speed filtering is switched on.
// - High speed survives repeated START, ends at next STOP.
// - General call address always acked; data acked only if 06h.
// - General call reset reloads the converter and ends high speed; store kept.
// - Internal reset happens automatically at power-up.
// - Reset loads stored code, or mid-scale if never programmed.
// - Store takes at most four writes in total.
// - Two-byte write, MSB first; output updates only after second.
// - Read returns two bytes; top nibble is thermometer write count.
// - Single byte 001xxxxx acquires stored code, zeros if blank.
`timescale 1ns/100ps
`default_nettype none
module twsd_front_end (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       two_pin_variant,
  input  wire logic       addr_select_low,
  input  wire logic       addr_select_high,
  output logic [9:0]      dac_code,
  output logic            hs_mode,
  output logic            otp_write_stb,
  output logic [3:0]      otp_count
);
  // ----------------------------------------------------------------
  // Synchronisation and conditions
  // ----------------------------------------------------------------
  twsd_pkg::twsd_lines_t  raw_lines;
  twsd_pkg::twsd_lines_t  lines;
  twsd_pkg::twsd_events_t ev;
  twsd_pkg::twsd_lines_t  pins_meta_q;
  twsd_pkg::twsd_lines_t  pins_q;

  assign raw_lines.scl = scl_in;
  assign raw_lines.sda = sda_in;

  twsd_sync u_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .lines_in  (raw_lines),
    .lines_out (lines)
  );

  twsd_events u_events (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lines   (lines),
    .ev      (ev)
  );

  // Select pins are static but still come from outside the domain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_meta_q <= '0;
      pins_q      <= '0;
    end else begin
      pins_meta_q <= '{scl: addr_select_high, sda: addr_select_low};
      pins_q      <= pins_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Address match
  // ----------------------------------------------------------------
  logic [6:0] own_addr;
  always_comb begin
    if (two_pin_variant) begin
      own_addr = {twsd_pkg::ADDR_FIXED_TWO_PIN, pins_q.scl,
                  pins_q.sda};
    end else begin
      own_addr = {twsd_pkg::ADDR_FIXED_ONE_PIN, pins_q.sda};
    end
  end

  // ----------------------------------------------------------------
  // Transaction state
  // ----------------------------------------------------------------
  twsd_pkg::twsd_state_t state_q;
  logic [3:0]  bit_q;
  logic [7:0]  shift_q;
  logic        ack_q;         // Acknowledge decided for this byte
  logic        first_q;       // Next byte is the first after address
  logic        write_q;       // Write transaction selected
  logic [7:0]  hi_q;          // First data byte of a write
  logic [1:0]  byte_q;        // Data bytes taken in this write
  logic [7:0]  tx_q;          // Read shift register
  logic        rd_lo_q;       // Second read byte in flight
  logic        gc_reset_q;    // Request for internal reset
  logic        int_rst;
  logic [7:0]  byte_in;

  // General call reset is its own internal reset, not rst, one cycle later
  assign int_rst = gc_reset_q;
  assign byte_in = {shift_q[6:0], lines.sda};

  // Sample data on rising clock; the ninth pulse carries acknowledge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= twsd_pkg::ST_IDLE;
      bit_q   <= 4'h0;
      shift_q <= 8'h00;
      ack_q   <= 1'b0;
      first_q <= 1'b0;
      write_q <= 1'b0;
    end else if (ev.stop) begin
      state_q <= twsd_pkg::ST_IDLE;
      bit_q   <= 4'h0;
    end else if (ev.start) begin
      state_q <= twsd_pkg::ST_ADDR;
      bit_q   <= 4'h0;
      first_q <= 1'b1;
    end else if (ev.rise) begin
      case (state_q)
        twsd_pkg::ST_ADDR, twsd_pkg::ST_WRX, twsd_pkg::ST_GCALL: begin
          if (bit_q == twsd_pkg::BIT_ACK) begin
            bit_q <= 4'h0;
          end else begin
            shift_q <= byte_in;
            bit_q   <= bit_q + 4'h1;
          end
        end
        twsd_pkg::ST_RDTX: begin
          if (bit_q == twsd_pkg::BIT_ACK) begin
            bit_q <= 4'h0;
            // Master not acknowledging ends the read
            if (lines.sda) begin
              state_q <= twsd_pkg::ST_IDLE;
            end
          end else begin
            bit_q <= bit_q + 4'h1;
          end
        end
        default: begin
        end
      endcase
    end else if (ev.fall) begin
      case (state_q)
        twsd_pkg::ST_ADDR: begin
          if (bit_q == twsd_pkg::BIT_ACK) begin
            if (shift_q[7:3] == twsd_pkg::HS_CODE_TOP) begin
              ack_q   <= 1'b0;
              state_q <= twsd_pkg::ST_IDLE;
            end else if (shift_q == twsd_pkg::GCALL_ADDR_BYTE) begin
              ack_q   <= 1'b1;
              state_q <= twsd_pkg::ST_GCALL;
            end else if (shift_q[7:1] == own_addr) begin
              ack_q   <= 1'b1;
              write_q <= ~shift_q[0];
              state_q <= shift_q[0] ? twsd_pkg::ST_RDTX
                                    : twsd_pkg::ST_WRX;
            end else begin
              ack_q   <= 1'b0;
              state_q <= twsd_pkg::ST_IDLE;
            end
          end else if (bit_q == 4'h0) begin
            ack_q <= 1'b0;
          end
        end
        twsd_pkg::ST_WRX: begin
          if (bit_q == twsd_pkg::BIT_ACK) begin
            ack_q   <= 1'b1;
            first_q <= 1'b0;
          end else if (bit_q == 4'h0) begin
            ack_q <= 1'b0;
          end
        end
        twsd_pkg::ST_GCALL: begin
          if (bit_q == twsd_pkg::BIT_ACK) begin
            ack_q <= (shift_q == twsd_pkg::GCALL_RESET_BYTE);
            first_q <= 1'b0;
          end else if (bit_q == 4'h0) begin
            ack_q <= 1'b0;
          end
        end
        twsd_pkg::ST_RDTX: begin
          // Address ack has ended; the next ack reloads the low byte, later ones load 8'hff
          if (bit_q == 4'h0) begin
            ack_q   <= 1'b0;
            first_q <= 1'b0;
          end
        end
        default: begin
          if (bit_q == 4'h0) begin
            ack_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Reset request fires when the acked data byte's ninth pulse ends;
  // the address byte's own ack still has first_q set and never fires
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gc_reset_q <= 1'b0;
    end else begin
      gc_reset_q <= ev.fall && state_q == twsd_pkg::ST_GCALL &&
                    bit_q == 4'h0 && ack_q && !first_q;
    end
  end

  // ----------------------------------------------------------------
  // High-speed mode
  // ----------------------------------------------------------------
  // Filtering is the synchroniser; the flag tells the analog filter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hs_mode <= 1'b0;
    end else if (int_rst || ev.stop) begin
      hs_mode <= 1'b0;
    end else if (ev.fall && state_q == twsd_pkg::ST_ADDR &&
                 bit_q == twsd_pkg::BIT_ACK &&
                 shift_q[7:3] == twsd_pkg::HS_CODE_TOP) begin
      hs_mode <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Converter, store and write decoding
  // ----------------------------------------------------------------
  logic [9:0] otp_code_q;
  logic       byte_done;
  logic       stop_single;

  // A whole data byte ends on the rise that samples its eighth bit
  assign byte_done = ev.rise && state_q == twsd_pkg::ST_WRX &&
                     bit_q == twsd_pkg::BIT_LAST;
  // Acquire is a lone byte closed by STOP
  assign stop_single = ev.stop && state_q == twsd_pkg::ST_WRX &&
                       byte_q == 2'h1 &&
                       hi_q[7:5] == twsd_pkg::CMD_ACQUIRE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_q <= 2'h0;
      hi_q   <= 8'h00;
    end else if (ev.start || ev.stop) begin
      byte_q <= 2'h0;
    end else if (byte_done) begin
      if (byte_q == 2'h0) begin
        hi_q   <= byte_in;
        byte_q <= 2'h1;
      end else begin
        byte_q <= 2'h0;
      end
    end
  end

  // Store count and code survive internal resets, like real OTP
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      otp_count     <= twsd_pkg::OTP_NONE;
      otp_code_q    <= twsd_pkg::DAC_ZERO;
      otp_write_stb <= 1'b0;
    end else begin
      otp_write_stb <= 1'b0;
      if (byte_done && byte_q == 2'h1 &&
          hi_q[7:5] == twsd_pkg::CMD_OTP_WRITE &&
          otp_count != twsd_pkg::OTP_FULL) begin
        otp_code_q    <= {hi_q[1:0], byte_in};
        otp_count     <= {otp_count[2:0], 1'b1};
        otp_write_stb <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dac_code <= twsd_pkg::DAC_MID;
    end else if (int_rst) begin
      dac_code <= (otp_count == twsd_pkg::OTP_NONE) ?
                  twsd_pkg::DAC_MID : otp_code_q;
    end else if (stop_single) begin
      dac_code <= otp_code_q;
    end else if (byte_done && byte_q == 2'h1) begin
      if (hi_q[7:5] == twsd_pkg::CMD_OTP_WRITE) begin
        if (otp_count != twsd_pkg::OTP_FULL) begin
          dac_code <= {hi_q[1:0], byte_in};
        end
      end else if (hi_q[7:5] != twsd_pkg::CMD_ACQUIRE) begin
        dac_code <= {hi_q[1:0], byte_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and line drive
  // ----------------------------------------------------------------
  // Load on the fall before the address ack, reload on the fall after each later ack; shift on the fall after each data bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_q    <= 8'hff;
      rd_lo_q <= 1'b0;
    end else if (ev.start || ev.stop) begin
      rd_lo_q <= 1'b0;
    end else if (ev.fall && state_q == twsd_pkg::ST_ADDR &&
                 bit_q == twsd_pkg::BIT_ACK) begin
      tx_q    <= {otp_count, 2'b00, dac_code[9:8]};
      rd_lo_q <= 1'b0;
    end else if (ev.fall && state_q == twsd_pkg::ST_RDTX) begin
      if (bit_q == 4'h0 && !first_q) begin
        tx_q    <= rd_lo_q ? 8'hff : dac_code[7:0];
        rd_lo_q <= 1'b1;
      end else if (bit_q != 4'h0) begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // First read byte follows the address ack; clear first_q there
  logic rd_drive;
  assign rd_drive = state_q == twsd_pkg::ST_RDTX &&
                    bit_q != twsd_pkg::BIT_ACK && !ack_q;

  // Drive moves only the cycle after a clock fall, once ack and shift
  // state have settled; moving in the high phase would fake a STOP
  logic fall_d_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fall_d_q <= 1'b0;
    end else begin
      fall_d_q <= ev.fall;
    end
  end

  // Open drain: only ever pull low, otherwise release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sda_oe <= 1'b0;
    end else if (fall_d_q) begin
      sda_oe <= ack_q | (rd_drive & ~tx_q[7]);
    end
  end
  assign sda_out = 1'b0;
endmodule : twsd_front_end
`default_nettype wire

// file: verification/twsd_props.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the two-wire front end
// ----------------------------------------------------------------
module twsd_props (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       two_pin_variant,
  input wire logic       addr_select_low,
  input wire logic       addr_select_high,
  input wire logic [9:0] dac_code,
  input wire logic       hs_mode,
  input wire logic       otp_write_stb,
  input wire logic [3:0] otp_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Open drain: the data pin may only ever be pulled low
  drive_low_a: assert property (
    sda_oe |-> !sda_out)
    else $error("data pin driven high");
  // Device takes the data line only in the low phase, after a fall
  oe_rise_a: assert property (
    $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data driven outside clock low");
  // The data line drive may not move while the clock is high
  oe_high_a: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data changed with clock high");
  // Programming status is a thermometer code
  count_thermo_a: assert property (
    otp_count inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("store count not thermometer");
  // Store write strobe is a single-cycle pulse
  stb_pulse_a: assert property (
    otp_write_stb |=> !otp_write_stb)
    else $error("store strobe too long");
  // Each accepted store write moves the count close to the strobe
  stb_count_a: assert property (
    otp_write_stb |-> ##[0:3] (otp_count != $past(otp_count, 4)))
    else $error("store strobe without count step");
  // Converter moves with clock high, save for the general call reset,
  // which lands while the reset byte's acknowledge is still driven
  dac_quiet_a: assert property (
    $changed(dac_code) |-> scl_in || $past(sda_oe))
    else $error("converter changed with clock low");
  // Released reset leaves the power-up state
  reset_state_a: assert property (
    $fell(rst) |-> !sda_oe && !hs_mode &&
      dac_code == twsd_pkg::DAC_MID && otp_count == twsd_pkg::OTP_NONE)
    else $error("wrong state after reset");
endmodule : twsd_props

bind twsd_front_end twsd_props u_props (
  .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .two_pin_variant(two_pin_variant),
  .addr_select_low(addr_select_low), .addr_select_high(addr_select_high),
  .dac_code(dac_code), .hs_mode(hs_mode), .otp_write_stb(otp_write_stb),
  .otp_count(otp_count));
`default_nettype wire

// file: verification/twsd_master.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Bus master model: 80 ns bit clock, open-drain data
// ----------------------------------------------------------------
module twsd_master (
  input  wire logic       sys_clk,
  input  wire logic       sda_line,
  output var  logic       scl,
  output var  logic       sda_low,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data
);
  // Idle bus: clock stands high, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // One bit; data only moves mid-low so the slave never sees a glitch
  task automatic bit_cycle(input logic b, output logic got);
    tick(5);
    sda_low = !b;
    tick(5);
    scl = 1'b1;
    tick(9);
    got = sda_line;
    tick(1);
    scl = 1'b0;
  endtask : bit_cycle
  // Hand one observed result to the bench
  task automatic report(input logic [7:0] v);
    rx_data = v;
    rx_valid = 1'b1;
    tick(1);
    rx_valid = 1'b0;
  endtask : report
  // START, or repeated START when the clock is low
  task automatic start();
    if (!scl) begin
      tick(5);
      sda_low = 1'b0;
      tick(5);
      scl = 1'b1;
    end
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(5);
    sda_low = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(10);
  endtask : stop
  // Eight bits MSB first, ninth pulse released; reports the acknowledge
  task automatic send_byte(input logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], g);
    end
    bit_cycle(1'b1, g);
    report({7'h00, !g});
  endtask : send_byte
  task automatic recv_byte(input logic mack);
    logic [7:0] d;
    logic       g;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(!mack, g);
    report(d);
  endtask : recv_byte
endmodule : twsd_master
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  logic       sys_clk;
  logic       rst;
  logic       two_pin;
  logic       sel_lo;
  logic       sel_hi;
  logic       scl;
  logic       m_low;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic [9:0] dac_code;
  logic       hs_mode;
  logic       stb;
  logic [3:0] otp_count;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic [7:0] exp_v;
  logic [7:0] expq[$];
  int         errors = 0;
  int         n_tests = 0;
  int         n_stb = 0;
  int         seed = 32'hd0a2;
  logic [9:0] code;
  logic [9:0] c;
  logic [9:0] stored;
  logic [3:0] cnt;
  logic [6:0] adr;
  logic [6:0] dev = 7'h76;
  logic       ack;

  always #2 sys_clk = ~sys_clk;
  // Wired-AND data line with pull-up
  assign sda = !(m_low || (sda_oe && !sda_out));

  twsd_front_end DUT (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .two_pin_variant(two_pin),
    .addr_select_low(sel_lo), .addr_select_high(sel_hi),
    .dac_code(dac_code), .hs_mode(hs_mode), .otp_write_stb(stb),
    .otp_count(otp_count));
  twsd_master m (
    .sys_clk(sys_clk), .sda_line(sda), .scl(scl), .sda_low(m_low),
    .rx_valid(rx_valid), .rx_data(rx_data));

  // Count store strobes
  always @(posedge sys_clk) begin
    if (stb === 1'b1) n_stb++;
  end
  // Each result from the master is matched with the oldest note
  always @(posedge rx_valid) begin
    exp_v = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
    `CHK(rx_data, exp_v)
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] d, input logic a);
    expq.push_back({7'h00, a});
    m.send_byte(d);
  endtask : wr
  task automatic rd(input logic [7:0] d, input logic mack);
    expq.push_back(d);
    m.recv_byte(mack);
  endtask : rd
  // Write with command bits; a one-byte write stops after the first
  task automatic xfer(input logic [2:0] cmd, input logic [9:0] v,
                      input logic two);
    m.start();
    wr({dev, 1'b0}, 1'b1);
    wr({cmd, 3'h0, v[9:8]}, 1'b1);
    if (two) wr(v[7:0], 1'b1);
    m.stop();
    m.tick(4);
  endtask : xfer
  // Read back both bytes, acking the first only
  task automatic rd_back();
    m.start();
    wr({dev, 1'b1}, 1'b1);
    rd({cnt, 2'b00, code[9:8]}, 1'b1);
    rd(code[7:0], 1'b0);
    m.stop();
  endtask : rd_back

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    two_pin = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    m.tick(8);
    `CHK(dac_code, 10'h200)
    // Address sweep over both variants and all select levels
    for (int v = 0; v < 2; v++) begin
      for (int p = 0; p < 4; p++) begin
        for (int a = 4; a < 8; a++) begin
          two_pin = v[0];
          sel_lo = p[0];
          sel_hi = p[1];
          adr = 7'h70 + a[6:0];
          if (v[0]) begin
            ack = (adr === {5'h1d, p[1], p[0]});
          end else begin
            ack = (adr === {6'h3b, p[0]});
          end
          m.tick(4);
          m.start();
          wr({adr, 1'b0}, ack);
          m.stop();
        end
      end
    end
    // One-pin part on random select levels; the high pin must not matter
    two_pin = 1'b0;
    sel_lo = 1'($random(seed));
    sel_hi = 1'($random(seed));
    dev = {6'h3b, sel_lo};
    m.tick(4);
    cnt = 4'h0;
    code = 10'($random(seed));
    xfer(3'h0, code, 1'b1);
    `CHK(dac_code, code)
    // Early STOP after the first byte leaves the output alone
    xfer(3'h0, ~code, 1'b0);
    `CHK(dac_code, code)
    xfer(3'h1, code, 1'b0);
    `CHK(dac_code, 10'h000)
    code = 10'h000;
    // Five store writes; the fifth finds the store full
    for (int i = 0; i < 5; i++) begin
      c = 10'($random(seed));
      xfer(3'h2, c, 1'b1);
      if (i < 4) begin
        stored = c;
        code = c;
        cnt = {cnt[2:0], 1'b1};
      end
      rd_back();
      `CHK(otp_count, cnt)
    end
    `CHK(n_stb, 4)
    xfer(3'h0, ~stored, 1'b1);
    xfer(3'h1, code, 1'b0);
    `CHK(dac_code, stored)
    // General call with a wrong data byte: refused, and no reset
    xfer(3'h0, ~stored, 1'b1);
    m.start();
    wr(8'h00, 1'b1);
    wr(8'h05, 1'b0);
    m.stop();
    m.tick(4);
    `CHK(dac_code, ~stored)
    // Reset code reloads the stored value and keeps the count
    m.start();
    wr(8'h00, 1'b1);
    wr(8'h06, 1'b1);
    m.stop();
    m.tick(4);
    `CHK(dac_code, stored)
    `CHK(otp_count, 4'hf)
    // Master code, any low bits, then repeated START keeps high speed
    m.start();
    wr({5'h01, 3'($random(seed))}, 1'b0);
    `CHK(hs_mode, 1'b1)
    m.start();
    wr({dev, 1'b0}, 1'b1);
    `CHK(hs_mode, 1'b1)
    m.stop();
    m.tick(8);
    `CHK(hs_mode, 1'b0)
    // Reset in mid-run
    rst = 1'b1;
    m.tick(2);
    rst = 1'b0;
    m.tick(4);
    `CHK(dac_code, 10'h200)
    `CHK(otp_count, 4'h0)
    end_of_test();
  end
endmodule : tb
`default_nettype wire
